/* verilog/usart_front_params.svh */
`ifndef USART_FRONT_PARAMS_SVH
`define USART_FRONT_PARAMS_SVH
// data bus width
`define BUS_W 8
// minimum reset width, in device clock periods
`define RESET_MIN_CYCLES 6
// reset value of every byte register
`define BYTE_RESET 8'h00
// command word bit that requests an internal reset
`define CMD_RESET_BIT 6
// status bit positions
`define ST_TX_READY 0
`define ST_RX_READY 1
`define ST_CONFIGURED 2
`define ST_IDLE 3
`endif

/* verilog/usart_front_pkg.sv */
package usart_front_pkg;
  // host bus strobes, already synchronised
  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic ctl;
  } host_ctl_s;
  // phase of the programming sequence
  typedef enum logic [1:0] {
    ST_IDLE_WAIT,
    ST_WAIT_CMD,
    ST_RUN
  } prog_state_e;
endpackage

/* verilog/sync2.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usart_front_params.svh"
module sync2 (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  logic meta;
  // two-stage synchroniser; meta feeds only q
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

/* verilog/usart_host_front.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usart_front_params.svh"
// How it works
// - eight-bit data lines are driven only when enabled, otherwise released.
// - bytes move only on host read or write cycles to the device.
// - configuration, command and status share the same eight-bit data lines.
// - command/status, incoming data and outgoing data are three separate byte registers.
// - decodes host strobes; holds configuration word and command word registers.
// - reset high forces idle, serial activity stopped, configuration unprogrammed.
// - stays idle until host writes a new configuration then command.
// - command word reset bit, written while running, gives the same idle state as reset input.
// - strobes without select change nothing.
// - status readable any time; status updates frozen during a status read.
module usart_host_front
  import usart_front_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reset_pin,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ctl_sel,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire logic tx_byte_taken,
  input wire logic [7:0] line_status,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  output logic [7:0] mode_word,
  output logic [7:0] cmd_word,
  output logic serial_enable
);
  // ****************************************
  // input synchronisers
  // ****************************************
  logic rst_pin_s, sel_s, rd_s, wr_s, ctl_s;
  logic [7:0] din_s1, din_s;
  host_ctl_s hc;
  sync2 u_rst (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(reset_pin), .q(rst_pin_s));
  sync2 u_sel (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(~sel_n), .q(sel_s));
  sync2 u_rd (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(~rd_n), .q(rd_s));
  sync2 u_wr (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(~wr_n), .q(wr_s));
  sync2 u_ctl (.clk_sys(clk_sys), .sys_rst(sys_rst), .d(ctl_sel), .q(ctl_s));
  // data byte synchroniser
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      din_s1 <= `BYTE_RESET;
      din_s <= `BYTE_RESET;
    end else begin
      din_s1 <= data_in;
      din_s <= din_s1;
    end
  end
  assign hc = '{sel: sel_s, rd: rd_s, wr: wr_s, ctl: ctl_s};

  // ****************************************
  // strobe decode
  // ****************************************
  logic wr_d, rd_d, wr_edge, rd_edge;
  logic wr_ctl, wr_data, rd_data, stat_rd;
  logic cmd_reset, idle_force;
  prog_state_e state, next_state;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_d <= 1'b0;
      rd_d <= 1'b0;
    end else begin
      wr_d <= hc.wr & hc.sel;
      rd_d <= hc.rd & hc.sel;
    end
  end
  // one pulse per selected cycle; unselected strobes ignored
  assign wr_edge = hc.sel & hc.wr & ~wr_d;
  assign rd_edge = hc.sel & hc.rd & ~rd_d;
  assign wr_ctl = wr_edge & hc.ctl;
  assign wr_data = wr_edge & ~hc.ctl;
  assign rd_data = rd_edge & ~hc.ctl;
  assign stat_rd = hc.sel & hc.rd & hc.ctl;
  assign cmd_reset = (state == ST_RUN) & wr_ctl & din_s[`CMD_RESET_BIT];
  assign idle_force = rst_pin_s | cmd_reset;

  // ****************************************
  // programming sequence
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE_WAIT: if (wr_ctl) next_state = ST_WAIT_CMD;
      ST_WAIT_CMD: if (wr_ctl) next_state = ST_RUN;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_IDLE_WAIT;
    endcase
    if (idle_force) begin
      next_state = ST_IDLE_WAIT;
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE_WAIT;
    end else begin
      state <= next_state;
    end
  end
  assign serial_enable = (state == ST_RUN);

  // ****************************************
  // configuration and command registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_word <= `BYTE_RESET;
      cmd_word <= `BYTE_RESET;
    end else if (idle_force) begin
      mode_word <= `BYTE_RESET;
      cmd_word <= `BYTE_RESET;
    end else if (wr_ctl && state == ST_IDLE_WAIT) begin
      mode_word <= din_s;
    end else if (wr_ctl) begin
      cmd_word <= din_s;
    end
  end

  // ****************************************
  // data registers
  // ****************************************
  logic [7:0] rx_hold;
  logic rx_full;
  // outgoing byte; taken by transmitter
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_byte <= `BYTE_RESET;
      tx_byte_valid <= 1'b0;
    end else if (idle_force) begin
      tx_byte_valid <= 1'b0;
    end else if (wr_data && serial_enable) begin
      tx_byte <= din_s;
      tx_byte_valid <= 1'b1;
    end else if (tx_byte_taken) begin
      tx_byte_valid <= 1'b0;
    end
  end
  // incoming byte; new data wins over host read clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_hold <= `BYTE_RESET;
      rx_full <= 1'b0;
    end else if (idle_force) begin
      rx_full <= 1'b0;
    end else if (rx_byte_valid && serial_enable) begin
      rx_hold <= rx_byte;
      rx_full <= 1'b1;
    end else if (rd_data) begin
      rx_full <= 1'b0;
    end
  end

  // ****************************************
  // status register, frozen while read
  // ****************************************
  logic [7:0] status, next_status;
  always_comb begin
    next_status = line_status;
    next_status[`ST_TX_READY] = ~tx_byte_valid & serial_enable;
    next_status[`ST_RX_READY] = rx_full;
    next_status[`ST_CONFIGURED] = (state != ST_IDLE_WAIT);
    next_status[`ST_IDLE] = (state == ST_IDLE_WAIT);
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status <= `BYTE_RESET;
    end else if (!stat_rd) begin
      status <= next_status;
    end
  end

  // ****************************************
  // bus buffer
  // ****************************************
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= `BYTE_RESET;
      data_oe <= 1'b0;
    end else begin
      data_oe <= hc.sel & hc.rd;
      data_out <= hc.ctl ? status : rx_hold;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_oe_only_read;
    @(posedge clk_sys) disable iff (sys_rst) data_oe |-> $past(hc.sel & hc.rd);
  endproperty
  a_oe_only_read: assert property (p_oe_only_read) else $error("bus driven outside read");
  property p_unsel_quiet;
    @(posedge clk_sys) disable iff (sys_rst)
      (!hc.sel && !idle_force) |=> $stable(mode_word) && $stable(cmd_word);
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet) else $error("unselected write changed state");
  property p_status_frozen;
    @(posedge clk_sys) disable iff (sys_rst) stat_rd |=> $stable(status);
  endproperty
  a_status_frozen: assert property (p_status_frozen) else $error("status moved during read");
  property p_pin_idle;
    @(posedge clk_sys) disable iff (sys_rst) rst_pin_s |=> state == ST_IDLE_WAIT && !serial_enable;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("reset pin did not idle");
  property p_cmd_idle;
    @(posedge clk_sys) disable iff (sys_rst) cmd_reset |=> state == ST_IDLE_WAIT && cmd_word == 8'h00;
  endproperty
  a_cmd_idle: assert property (p_cmd_idle) else $error("command reset did not idle");
  property p_need_two_words;
    @(posedge clk_sys) disable iff (sys_rst)
      (state == ST_IDLE_WAIT && !wr_ctl) |=> !serial_enable;
  endproperty
  a_need_two_words: assert property (p_need_two_words) else $error("ran without programming");
  property p_mode_load;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_ctl && state == ST_IDLE_WAIT && !idle_force) |=> mode_word == $past(din_s);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode word not stored");
  property p_tx_load;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_data && serial_enable && !idle_force) |=> tx_byte_valid && tx_byte == $past(din_s);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("data byte not stored");
endmodule
`default_nettype wire

/* verif/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic ctl_sel,
  output logic [7:0] data_in,
  output logic reset_pin
);
  // ****************
  // host bus master
  // ****************
  logic drv = 1'b0;
  logic [7:0] wv = 8'h00;
  // released bus shows the inverse of the last host byte
  assign data_in = data_oe ? data_out : (drv ? wv : ~wv);
  // idle bus levels
  initial begin
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ctl_sel = 1'b0;
    reset_pin = 1'b0;
  end
  // one write cycle, strobe low four clocks
  task automatic wr(input logic c, input logic [7:0] b, input logic s);
    @(posedge clk_sys);
    sel_n <= ~s;
    ctl_sel <= c;
    wv <= b;
    drv <= 1'b1;
    wr_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr_n <= 1'b1;
    sel_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    drv <= 1'b0;
  endtask
  // one read cycle, data taken at the last low edge
  task automatic rd(input logic c, input logic s, output logic [7:0] b, output logic oe);
    @(posedge clk_sys);
    sel_n <= ~s;
    ctl_sel <= c;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    b = data_out;
    oe = data_oe;
    rd_n <= 1'b1;
    sel_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask
  // reset pin held six clocks with the clock running
  task automatic pin_reset();
    @(posedge clk_sys);
    reset_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reset_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****************
  // bench
  // ****************
  logic clk_sys, sys_rst, reset_pin, sel_n, rd_n, wr_n, ctl_sel, data_oe;
  logic rx_byte_valid, tx_byte_taken, tx_byte_valid, serial_enable;
  logic [7:0] data_in, data_out, rx_byte, line_status, tx_byte, mode_word, cmd_word, b;
  logic oe;
  int error_cnt = 0;
  int cmp_count = 0;
  host_model host (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .sel_n(sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .ctl_sel(ctl_sel), .data_in(data_in), .reset_pin(reset_pin));
  usart_host_front dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reset_pin(reset_pin),
    .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .ctl_sel(ctl_sel), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .tx_byte_taken(tx_byte_taken), .line_status(line_status), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .mode_word(mode_word), .cmd_word(cmd_word),
    .serial_enable(serial_enable));
  // compare helper
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // mode then command brings the block to run
  task automatic program_words();
    host.wr(1'b1, 8'h4e, 1'b1);
    host.wr(1'b1, 8'h15, 1'b1);
    chk("mode_word", 8'h4e, mode_word);
    chk("cmd_word", 8'h15, cmd_word);
    chk("serial_enable", 8'h01, {7'h00, serial_enable});
  endtask
  // outgoing byte stored and released by the transmitter
  task automatic tx_path();
    host.wr(1'b0, 8'ha5, 1'b1);
    chk("tx_byte", 8'ha5, tx_byte);
    chk("tx_byte_valid", 8'h01, {7'h00, tx_byte_valid});
    tx_byte_taken <= 1'b1;
    @(posedge clk_sys);
    tx_byte_taken <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("tx_byte_valid", 8'h00, {7'h00, tx_byte_valid});
  endtask
  // incoming byte and status through the shared bus
  task automatic rx_path();
    rx_byte <= 8'h3c;
    rx_byte_valid <= 1'b1;
    @(posedge clk_sys);
    rx_byte_valid <= 1'b0;
    host.rd(1'b1, 1'b1, b, oe);
    chk("status_hi", 8'h0a, {4'h0, b[7:4]});
    chk("status_lo", 8'h03, {5'h00, b[3:1]});
    host.rd(1'b0, 1'b1, b, oe);
    chk("rx_data", 8'h3c, b);
    chk("data_oe", 8'h01, {7'h00, oe});
    chk("data_oe_idle", 8'h00, {7'h00, data_oe});
    host.rd(1'b1, 1'b1, b, oe);
    chk("status_rx", 8'h00, {7'h00, b[1]});
  endtask
  // strobes without select change nothing
  task automatic unselected();
    host.wr(1'b1, 8'h40, 1'b0);
    chk("cmd_word", 8'h15, cmd_word);
    host.rd(1'b0, 1'b0, b, oe);
    chk("data_oe", 8'h00, {7'h00, oe});
  endtask
  // command reset, then data refused until reprogrammed
  task automatic cmd_reset();
    host.wr(1'b1, 8'h40, 1'b1);
    chk("serial_enable", 8'h00, {7'h00, serial_enable});
    chk("mode_word", 8'h00, mode_word);
    host.wr(1'b0, 8'h77, 1'b1);
    chk("tx_byte_valid", 8'h00, {7'h00, tx_byte_valid});
  endtask
  // reset pin forces idle
  task automatic pin_reset_idle();
    host.pin_reset();
    chk("serial_enable", 8'h00, {7'h00, serial_enable});
    chk("cmd_word", 8'h00, cmd_word);
  endtask
  // clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // watchdog
  initial begin
    #200us;
    error_cnt++;
    stop_test();
  end
  // main sequence
  initial begin
    sys_rst = 1'b1;
    rx_byte = 8'h00;
    rx_byte_valid = 1'b0;
    tx_byte_taken = 1'b0;
    line_status = 8'ha0;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk("serial_enable", 8'h00, {7'h00, serial_enable});
    program_words();
    tx_path();
    rx_path();
    unselected();
    cmd_reset();
    program_words();
    pin_reset_idle();
    stop_test();
  end
endmodule
`default_nettype wire
